//--- core/cprs_pkg.sv
// package of constants and carriers for the cpu register set
// Functional notes
// - eight-bit accumulator holds operands and results; reset leaves it alone.
// - eight-bit index register for indexed addresses; reset leaves it alone.
// - sixteen-bit program counter advances by one per fetched byte.
// - jumps, calls and interrupt entry load the counter with target.
// - stack pointer goes to top of page on reset and reload instruction.
// - push decrements stack pointer, pull increments, pointing at next free.
// - stack address forces upper ten bits to fixed pattern, six low bits.
// - stack limited to 64 bytes; overflow wraps silently, overwriting data.
// - subroutine call pushes two bytes, interrupt entry pushes five.
// - low counter byte pushed first then high and rest; pull reverses.
// - five-bit condition flags, four result flags and one interrupt mask.
// - reset changes only the interrupt mask, result flags stay.
// - 32K map; address bit 15 never affects selection.
// - mask set after reset; only clear-mask or a flag byte restored by return clears it.
// - interrupt entry sets mask after stacking, before vector; return restores.
package cprs_pkg;
  localparam logic [15:0] CPRS_SP_TOP = 16'h00ff;
  localparam logic [9:0] CPRS_SP_HIGH = 10'h003;
  localparam int CPRS_SP_BITS = 6;
  localparam int CPRS_CALL_BYTES = 2;
  localparam int CPRS_INT_BYTES = 5;
  localparam logic [14:0] CPRS_ADDR_MASK = 15'h7fff;
  // condition flag bit positions
  localparam int CPRS_F_C = 0;
  localparam int CPRS_F_Z = 1;
  localparam int CPRS_F_N = 2;
  localparam int CPRS_F_I = 3;
  localparam int CPRS_F_H = 4;
  // register port offsets
  localparam logic [3:0] CPRS_OFS_ACC = 4'h0;
  localparam logic [3:0] CPRS_OFS_IDX = 4'h1;
  localparam logic [3:0] CPRS_OFS_PCL = 4'h2;
  localparam logic [3:0] CPRS_OFS_PCH = 4'h3;
  localparam logic [3:0] CPRS_OFS_SP = 4'h4;
  localparam logic [3:0] CPRS_OFS_CCR = 4'h5;
  localparam logic [3:0] CPRS_OFS_STAT = 4'h6;
  // core command codes
  typedef enum logic [3:0] {
    CPRS_OP_NONE = 4'h0,
    CPRS_OP_FETCH = 4'h1,
    CPRS_OP_JUMP = 4'h2,
    CPRS_OP_CALL = 4'h3,
    CPRS_OP_RTS = 4'h4,
    CPRS_OP_INT = 4'h5,
    CPRS_OP_RTI = 4'h6,
    CPRS_OP_RSP = 4'h7,
    CPRS_OP_CLI = 4'h8,
    CPRS_OP_SEI = 4'h9,
    CPRS_OP_FLAGS = 4'ha
  } cprs_op_t;
  // command from the sequencer
  typedef struct packed {
    cprs_op_t op;
    logic [15:0] target;
    logic [3:0] flags;
  } cprs_cmd_t;
  // memory request toward the bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [14:0] addr;
    logic [7:0] wdata;
  } cprs_mem_t;
endpackage

//--- core/cprs_stack_addr.sv
// stack address former for the cpu register set
`timescale 1ns/100ps
`default_nettype none
module cprs_stack_addr
  import cprs_pkg::*;
(
  // stack pointer in
  input wire logic [15:0] sp,
  // bus address out
  output logic [14:0] addr
);
  logic [15:0] full;
  // fixed high pattern joined to six low bits
  assign full = {CPRS_SP_HIGH, sp[CPRS_SP_BITS-1:0]};
  assign addr = full[14:0] & CPRS_ADDR_MASK;
endmodule
`default_nettype wire

//--- core/cprs_regset.sv
// cpu programmer register set with stacking sequencer
`timescale 1ns/100ps
`default_nettype none
module cprs_regset
  import cprs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // core command
  input wire cprs_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  // memory side
  output cprs_mem_t mem,
  input wire logic [7:0] mem_rdata,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // register views
  output logic [15:0] pc_out,
  output logic [4:0] ccr_out
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PUSH = 4'b0010,
    ST_PULL = 4'b0100,
    ST_DONE = 4'b1000
  } cprs_st_t;

  typedef struct packed {
    cprs_st_t st;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [4:0] condition_flags;
    logic [2:0] cnt;
    logic [2:0] total;
    logic is_int;
    logic [15:0] target;
    logic pull_wait;
    cprs_mem_t mem;
    logic [7:0] rdata;
  } cprs_state_t;

  cprs_state_t s_reg;
  cprs_state_t s_next;
  logic [14:0] sp_addr;

  cprs_stack_addr u_sa (
    .sp(s_reg.sp),
    .addr(sp_addr)
  );

  // byte pushed at step n: low pc, high pc, idx, acc, ccr
  function automatic logic [7:0] push_byte(input cprs_state_t s,
                                           input logic [2:0] n);
    case (n)
      3'h0: push_byte = s.pc[7:0];
      3'h1: push_byte = s.pc[15:8];
      3'h2: push_byte = s.idx;
      3'h3: push_byte = s.acc;
      3'h4: push_byte = {3'h0, s.condition_flags};
      default: push_byte = 8'h00;
    endcase
  endfunction

  // register read decode
  function automatic logic [7:0] rd_mux(input cprs_state_t s,
                                        input logic [3:0] a);
    case (a)
      CPRS_OFS_ACC: rd_mux = s.acc;
      CPRS_OFS_IDX: rd_mux = s.idx;
      CPRS_OFS_PCL: rd_mux = s.pc[7:0];
      CPRS_OFS_PCH: rd_mux = s.pc[15:8];
      CPRS_OFS_SP: rd_mux = s.sp[7:0];
      CPRS_OFS_CCR: rd_mux = {3'h0, s.condition_flags};
      CPRS_OFS_STAT: rd_mux = {4'h0, s.st};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // stack pointer step, wraps in 64-byte page
  function automatic logic [15:0] sp_step(input logic [15:0] sp,
                                          input logic up);
    logic [5:0] lo;
    lo = up ? sp[5:0] + 6'h01 : sp[5:0] - 6'h01;
    sp_step = {CPRS_SP_HIGH, lo};
  endfunction

  assign cmd_ready = (s_reg.st == ST_IDLE);
  assign mem = s_reg.mem;
  assign reg_rdata = s_reg.rdata;
  assign pc_out = s_reg.pc;
  assign ccr_out = s_reg.condition_flags;

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.mem = '0;
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      s_next.rdata = rd_mux(s_reg, reg_addr);
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (reg_wr) begin
          case (reg_addr)
            CPRS_OFS_ACC: s_next.acc = reg_wdata;
            CPRS_OFS_IDX: s_next.idx = reg_wdata;
            CPRS_OFS_PCL: s_next.pc[7:0] = reg_wdata;
            CPRS_OFS_PCH: s_next.pc[15:8] = reg_wdata;
            CPRS_OFS_SP: s_next.sp = {CPRS_SP_HIGH, reg_wdata[5:0]};
            CPRS_OFS_CCR: begin
              // software sets the flags; the mask only moves by command
              s_next.condition_flags = reg_wdata[4:0];
              s_next.condition_flags[CPRS_F_I] = s_reg.condition_flags[CPRS_F_I];
            end
            default: s_next.rdata = s_next.rdata;
          endcase
        end
        if (cmd_valid) begin
          case (cmd.op)
            CPRS_OP_FETCH: s_next.pc = s_reg.pc + 16'h0001;
            CPRS_OP_JUMP: s_next.pc = cmd.target;
            CPRS_OP_RSP: s_next.sp = CPRS_SP_TOP;
            CPRS_OP_CLI: s_next.condition_flags[CPRS_F_I] = 1'b0;
            CPRS_OP_SEI: s_next.condition_flags[CPRS_F_I] = 1'b1;
            CPRS_OP_FLAGS: begin
              s_next.condition_flags[CPRS_F_C] = cmd.flags[0];
              s_next.condition_flags[CPRS_F_Z] = cmd.flags[1];
              s_next.condition_flags[CPRS_F_N] = cmd.flags[2];
              s_next.condition_flags[CPRS_F_H] = cmd.flags[3];
            end
            CPRS_OP_CALL, CPRS_OP_INT: begin
              s_next.st = ST_PUSH;
              s_next.cnt = 3'h0;
              s_next.is_int = (cmd.op == CPRS_OP_INT);
              s_next.total = (cmd.op == CPRS_OP_INT) ?
                3'(CPRS_INT_BYTES) : 3'(CPRS_CALL_BYTES);
              s_next.target = cmd.target;
            end
            CPRS_OP_RTS, CPRS_OP_RTI: begin
              s_next.st = ST_PULL;
              s_next.is_int = (cmd.op == CPRS_OP_RTI);
              s_next.total = (cmd.op == CPRS_OP_RTI) ?
                3'(CPRS_INT_BYTES) : 3'(CPRS_CALL_BYTES);
              s_next.cnt = s_next.total - 3'h1;
              s_next.pull_wait = 1'b0;
            end
            default: s_next.st = ST_IDLE;
          endcase
        end
      end
      ST_PUSH: begin
        // write at sp, then step down
        s_next.mem.valid = 1'b1;
        s_next.mem.write = 1'b1;
        s_next.mem.addr = sp_addr;
        s_next.mem.wdata = push_byte(s_reg, s_reg.cnt);
        s_next.sp = sp_step(s_reg.sp, 1'b0);
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt == s_reg.total - 3'h1) begin
          s_next.st = ST_DONE;
          if (s_reg.is_int) begin
            s_next.condition_flags[CPRS_F_I] = 1'b1;
          end
        end
      end
      ST_PULL: begin
        // pre-increment, read, capture next cycle
        if (!s_reg.pull_wait) begin
          s_next.sp = sp_step(s_reg.sp, 1'b1);
          s_next.pull_wait = 1'b1;
        end else begin
          s_next.mem.valid = 1'b1;
          s_next.mem.addr = sp_addr;
          s_next.pull_wait = 1'b0;
          s_next.st = ST_DONE;
          s_next.target = {8'h00, 8'h00};
        end
      end
      ST_DONE: begin
        if (s_reg.mem.valid && !s_reg.mem.write) begin
          // pulled byte arrives; reverse order of pushes
          case (s_reg.cnt)
            3'h4: s_next.condition_flags = mem_rdata[4:0];
            3'h3: s_next.acc = mem_rdata;
            3'h2: s_next.idx = mem_rdata;
            3'h1: s_next.pc[15:8] = mem_rdata;
            default: s_next.pc[7:0] = mem_rdata;
          endcase
          if (s_reg.cnt == 3'h0) begin
            s_next.st = ST_IDLE;
          end else begin
            s_next.cnt = s_reg.cnt - 3'h1;
            s_next.st = ST_PULL;
          end
        end else begin
          s_next.pc = s_reg.target;
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // state register; reset touches only sp, mask, pc and control
  always_ff @(posedge mclk) begin
    s_reg <= s_next;
    if (!rst_n) begin
      s_reg.st <= ST_IDLE;
      s_reg.sp <= CPRS_SP_TOP;
      s_reg.condition_flags[CPRS_F_I] <= 1'b1;
      s_reg.cnt <= 3'h0;
      s_reg.total <= 3'h0;
      s_reg.is_int <= 1'b0;
      s_reg.pull_wait <= 1'b0;
      s_reg.mem <= '0;
      s_reg.rdata <= 8'h00;
      s_reg.pc <= 16'h0000;
      s_reg.target <= 16'h0000;
    end
  end

  // checks
  property p_reset_sp;
    @(posedge mclk) !rst_n |=> s_reg.sp == CPRS_SP_TOP;
  endproperty
  a_reset_sp: assert property (p_reset_sp) else $error("sp not top");

  property p_reset_mask;
    @(posedge mclk) !rst_n |=> s_reg.condition_flags[CPRS_F_I];
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("mask clr");

  // first reset edge after running: result flags kept
  property p_reset_flags;
    @(posedge mclk) !rst_n && $past(rst_n)
      |=> s_reg.condition_flags[2:0] == $past(s_reg.condition_flags[2:0]) &&
      s_reg.condition_flags[CPRS_F_H] == $past(s_reg.condition_flags[CPRS_F_H]);
  endproperty
  a_reset_flags: assert property (p_reset_flags)
    else $error("flags hit");

  property p_reset_acc;
    @(posedge mclk) !rst_n && $past(rst_n)
      |=> s_reg.acc == $past(s_reg.acc) &&
      s_reg.idx == $past(s_reg.idx);
  endproperty
  a_reset_acc: assert property (p_reset_acc) else $error("acc hit");

  property p_fetch;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_FETCH && !reg_wr
      |=> s_reg.pc == $past(s_reg.pc) + 16'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("pc no step");

  property p_jump;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_JUMP
      |=> s_reg.pc == $past(cmd.target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump lost");

  property p_sp_page;
    @(posedge mclk) disable iff (!rst_n) s_reg.sp[15:6] == CPRS_SP_HIGH;
  endproperty
  a_sp_page: assert property (p_sp_page) else $error("sp off page");

  property p_call_bytes;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_CALL && !reg_wr
      |=> ##2 s_reg.sp[5:0] == $past(s_reg.sp[5:0], 3) - 6'h02;
  endproperty
  a_call_bytes: assert property (p_call_bytes) else $error("call");

  property p_int_mask;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_INT
      |=> !mem.valid ##1 mem.valid [*5] ##0 s_reg.condition_flags[CPRS_F_I];
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("int mask");

  property p_first_low;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_CALL
      |=> ##1 mem.wdata == $past(s_reg.pc[7:0], 2);
  endproperty
  a_first_low: assert property (p_first_low) else $error("order");

  // reload instruction puts the pointer back on top
  property p_rsp;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_RSP
      |=> s_reg.sp == CPRS_SP_TOP;
  endproperty
  a_rsp: assert property (p_rsp) else $error("rsp lost");

  // each push steps the pointer down by one
  property p_push_step;
    @(posedge mclk) disable iff (!rst_n)
      s_reg.st == ST_PUSH |=> s_reg.sp[5:0] == $past(s_reg.sp[5:0]) - 6'h01;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push step");

  // each pull steps the pointer up by one before the read
  property p_pull_step;
    @(posedge mclk) disable iff (!rst_n)
      s_reg.st == ST_PULL && !s_reg.pull_wait
      |=> s_reg.sp[5:0] == $past(s_reg.sp[5:0]) + 6'h01;
  endproperty
  a_pull_step: assert property (p_pull_step) else $error("pull step");

  // every stack access lands in the fixed page
  property p_stack_addr;
    @(posedge mclk) disable iff (!rst_n)
      mem.valid |-> mem.addr[14:6] == CPRS_SP_HIGH[8:0];
  endproperty
  a_stack_addr: assert property (p_stack_addr) else $error("stk addr");

  // mask falls only by clear command or by a restored flag byte
  property p_mask_fall;
    @(posedge mclk) disable iff (!rst_n)
      $fell(s_reg.condition_flags[CPRS_F_I])
      |-> $past(cmd_valid && cmd_ready && cmd.op == CPRS_OP_CLI) ||
      $past(s_reg.st == ST_DONE && s_reg.mem.valid && !s_reg.mem.write &&
      s_reg.cnt == 3'h4);
  endproperty
  a_mask_fall: assert property (p_mask_fall) else $error("mask fell");

  // call ends with the target loaded and the sequencer free
  property p_call_done;
    @(posedge mclk) disable iff (!rst_n)
      cmd_valid && cmd_ready && cmd.op == CPRS_OP_CALL && !reg_wr
      |=> ##3 s_reg.pc == $past(cmd.target, 4) && cmd_ready;
  endproperty
  a_call_done: assert property (p_call_done) else $error("call end");

  c_call: cover property (@(posedge mclk) cmd_valid && cmd.op == CPRS_OP_CALL);
  c_int: cover property (@(posedge mclk) cmd_valid && cmd.op == CPRS_OP_INT);
  c_rti: cover property (@(posedge mclk) cmd_valid && cmd.op == CPRS_OP_RTI);
  c_rsp: cover property (@(posedge mclk) cmd_valid && cmd.op == CPRS_OP_RSP);
  c_wrap: cover property (@(posedge mclk) s_reg.sp[5:0] == 6'h3f &&
    $past(s_reg.sp[5:0]) == 6'h00);
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the cpu register set
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cprs_pkg::*;
  logic mclk;
  logic rst_n;
  cprs_cmd_t cmd;
  logic cmd_valid;
  logic cmd_ready;
  cprs_mem_t mem;
  logic [7:0] mem_rdata;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [15:0] pc_out;
  logic [4:0] ccr_out;
  int error_cnt;
  int compares;
  integer seed;
  logic [23:0] memq[$];
  logic [7:0] rdq[$];
  logic [7:0] stk[64];
  logic [7:0] mstk[64];
  logic [7:0] m_sp, m_acc, m_idx;
  logic [15:0] m_pc;
  logic [4:0] m_ccr;
  logic rd_q;
  logic [7:0] r;

  cprs_regset cprs_regset_inst (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .mem(mem),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pc_out(pc_out), .ccr_out(ccr_out));

  // clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // stack memory answers in the cycle of the read request
  always_comb begin
    mem_rdata = (mem.valid && !mem.write) ? stk[mem.addr[5:0]] : 8'h00;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watcher: takes the oldest note whenever a result shows
  always @(negedge mclk) begin
    if (rd_q) begin
      if (rdq.size() == 0) check(24'h1, 24'h0);
      else check({16'h0, reg_rdata}, {16'h0, rdq.pop_front()});
    end
    rd_q <= reg_rd;
    if (mem.valid) begin
      if (mem.write) stk[mem.addr[5:0]] <= mem.wdata;
      if (memq.size() == 0) check(24'h2, 24'h0);
      else check({mem.write, mem.addr, mem.write ? mem.wdata : 8'h00},
        memq.pop_front());
    end
  end

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge mclk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) check(24'h3, 24'h0);
  endtask

  // one register port cycle; reads note the expected data
  task automatic reg_acc(input logic wr, input logic [3:0] a,
    input logic [7:0] d, input logic [7:0] exp);
    wait_idle();
    reg_addr <= a;
    reg_wdata <= d;
    if (wr) reg_wr <= 1'b1;
    else begin
      reg_rd <= 1'b1;
      rdq.push_back(exp);
    end
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // stack model: address from page pattern and six pointer bits
  task automatic push(input logic [7:0] b);
    memq.push_back({1'b1, 9'h003, m_sp[5:0], b});
    mstk[m_sp[5:0]] = b;
    m_sp = m_sp - 8'h01;
  endtask

  task automatic pull(output logic [7:0] b);
    m_sp = m_sp + 8'h01;
    memq.push_back({1'b0, 9'h003, m_sp[5:0], 8'h00});
    b = mstk[m_sp[5:0]];
  endtask

  task automatic do_cmd(input cprs_op_t op, input logic [15:0] t,
    input logic [3:0] f);
    logic [7:0] h, l, c;
    case (op)
      CPRS_OP_FETCH: m_pc = m_pc + 16'h0001;
      CPRS_OP_JUMP: m_pc = t;
      CPRS_OP_CALL: begin
        push(m_pc[7:0]);
        push(m_pc[15:8]);
        m_pc = t;
      end
      CPRS_OP_INT: begin
        push(m_pc[7:0]);
        push(m_pc[15:8]);
        push(m_idx);
        push(m_acc);
        push({3'h0, m_ccr});
        m_ccr[CPRS_F_I] = 1'b1;
        m_pc = t;
      end
      CPRS_OP_RTS: begin
        pull(h);
        pull(l);
        m_pc = {h, l};
      end
      CPRS_OP_RTI: begin
        pull(c);
        pull(m_acc);
        pull(m_idx);
        pull(h);
        pull(l);
        m_ccr = c[4:0];
        m_pc = {h, l};
      end
      CPRS_OP_RSP: m_sp = 8'hff;
      CPRS_OP_CLI: m_ccr[CPRS_F_I] = 1'b0;
      CPRS_OP_SEI: m_ccr[CPRS_F_I] = 1'b1;
      CPRS_OP_FLAGS: m_ccr = {f[3], m_ccr[CPRS_F_I], f[2:0]};
      default: ;
    endcase
    wait_idle();
    cmd <= '{op, t, f};
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask

  // read back every register and the views
  task automatic views();
    reg_acc(1'b0, CPRS_OFS_ACC, 8'h00, m_acc);
    reg_acc(1'b0, CPRS_OFS_IDX, 8'h00, m_idx);
    reg_acc(1'b0, CPRS_OFS_PCL, 8'h00, m_pc[7:0]);
    reg_acc(1'b0, CPRS_OFS_PCH, 8'h00, m_pc[15:8]);
    reg_acc(1'b0, CPRS_OFS_CCR, 8'h00, {3'h0, m_ccr});
    reg_acc(1'b0, CPRS_OFS_SP, 8'h00, {2'b11, m_sp[5:0]});
    reg_acc(1'b0, CPRS_OFS_STAT, 8'h00, 8'h01);
    check({3'h0, pc_out, ccr_out}, {3'h0, m_pc, m_ccr});
  endtask

  task automatic do_reset(input int cyc);
    rst_n <= 1'b0;
    repeat (cyc) @(posedge mclk);
    rst_n <= 1'b1;
    m_sp = 8'hff;
    m_pc = 16'h0000;
    m_ccr[CPRS_F_I] = 1'b1;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    seed = 48;
    error_cnt = 0;
    compares = 0;
    rst_n = 1'b0;
    cmd = '0;
    cmd_valid = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    do_reset(6);
    wait_idle();
    check({8'h0, pc_out}, 24'h0);
    check({23'h0, ccr_out[CPRS_F_I]}, 24'h1);
    m_acc = 8'($random(seed));
    m_idx = 8'($random(seed));
    m_pc = 16'($random(seed));
    reg_acc(1'b1, CPRS_OFS_ACC, m_acc, 8'h00);
    reg_acc(1'b1, CPRS_OFS_IDX, m_idx, 8'h00);
    reg_acc(1'b1, CPRS_OFS_PCL, m_pc[7:0], 8'h00);
    reg_acc(1'b1, CPRS_OFS_PCH, m_pc[15:8], 8'h00);
    reg_acc(1'b1, 4'hf, 8'h5a, 8'h00);
    reg_acc(1'b0, 4'hf, 8'h00, 8'h00);
    for (int i = 0; i < 16; i++) do_cmd(CPRS_OP_FLAGS, 16'h0, 4'(i));
    do_cmd(CPRS_OP_NONE, 16'h0, 4'h0);
    // software flag write keeps the mask; pointer write stays in page
    r = 8'($random(seed));
    m_ccr = {r[4], m_ccr[CPRS_F_I], r[2:0]};
    reg_acc(1'b1, CPRS_OFS_CCR, r, 8'h00);
    r = 8'($random(seed));
    m_sp = {2'b11, r[5:0]};
    reg_acc(1'b1, CPRS_OFS_SP, r, 8'h00);
    views();
    // fetches and jump
    for (int i = 0; i < 3; i++) do_cmd(CPRS_OP_FETCH, 16'h0, 4'h0);
    views();
    do_cmd(CPRS_OP_JUMP, 16'($random(seed)), 4'h0);
    views();
    // call, interrupt entry with mask clear, then returns
    do_cmd(CPRS_OP_CALL, 16'($random(seed)), 4'h0);
    do_cmd(CPRS_OP_CLI, 16'h0, 4'h0);
    do_cmd(CPRS_OP_FLAGS, 16'h0, 4'($random(seed)));
    do_cmd(CPRS_OP_INT, 16'($random(seed)), 4'h0);
    views();
    do_cmd(CPRS_OP_RTI, 16'h0, 4'h0);
    views();
    do_cmd(CPRS_OP_RTS, 16'h0, 4'h0);
    views();
    // 33 calls wrap the 64-byte page
    for (int i = 0; i < 33; i++) do_cmd(CPRS_OP_CALL, 16'($random(seed)), 4'h0);
    do_cmd(CPRS_OP_RTS, 16'h0, 4'h0);
    views();
    do_cmd(CPRS_OP_RSP, 16'h0, 4'h0);
    do_cmd(CPRS_OP_CALL, 16'($random(seed)), 4'h0);
    do_cmd(CPRS_OP_SEI, 16'h0, 4'h0);
    do_cmd(CPRS_OP_CLI, 16'h0, 4'h0);
    views();
    // reset in mid-run keeps acc, idx and result flags
    do_reset(2);
    views();
    do_cmd(CPRS_OP_CALL, 16'($random(seed)), 4'h0);
    views();
    repeat (2) @(posedge mclk);
    check(24'(memq.size() + rdq.size()), 24'h0);
    close_out();
  end
endmodule
`default_nettype wire
